// >>> design/eeprom_client.sv
// two-wire serial eeprom client: read paths, ack polling and node identifier
// assumes scl and sda arrive asynchronously from pins; sda is open drain
// and the testbench resolves the wire from sdaOe alone, sdaOut left open
`timescale 1ns/10ps
`default_nettype none

module eeprom_client
  import eeprom_pkg::*;
#(
  parameter int          WRITE_CYC = WRITE_CYCLES,  // shorten for simulation
  parameter bit          ID_IS_64  = 1'b0,          // identifier variant
  parameter logic [23:0] ID_PREFIX = 24'h5a5a5a,    // arbitrary value
  parameter logic [39:0] ID_EXT    = 40'h0102030405 // arbitrary value
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // serial pins
  input  wire logic scl,
  input  wire logic sdaIn,
  output var  logic sdaOut,
  output var  logic sdaOe,
  // status
  output var  logic writeBusy
);

  // ------------------------------------------------------------
  // identifier helpers
  // ------------------------------------------------------------

  // extension with the reserved leading words steered away
  // reserved lead words never shipped
  function automatic logic [39:0] safeExt(input logic [39:0] ext);
    logic [39:0] fixedExt;
    fixedExt = ext;
    if (ext[39:24] == ENCAP_WORD || ext[39:24] == RESV_WORD) begin
      fixedExt[32] = 1'b0;
    end
    return fixedExt;
  endfunction

  // reset content of one array location
  function automatic logic [7:0] memInit(input int idx);
    logic [63:0] idBits;
    logic [7:0]  firstId;
    int          offs;
    idBits  = ID_IS_64 ? {ID_PREFIX, safeExt(ID_EXT)} : {16'h0000, ID_PREFIX, ID_EXT[23:0]};
    firstId = ID_IS_64 ? ID64_BASE : ID48_BASE;
    offs    = int'(ARRAY_LAST) - idx;
    if (idx >= int'(firstId)) begin
      return idBits[offs*8 +: 8];
    end else if (idx >= int'(PROT_BASE)) begin
      return FILL_HIGH;
    end
    return FILL_LOW;
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic              sclMeta, sclS, sclP;   // scl synchroniser and history
  logic              sdaMeta, sdaS, sdaP;   // sda synchroniser and history
  logic              sclRise, sclFall;      // scl edges
  logic              startSeen, stopSeen;   // bus conditions
  xfer_state_t       state;                 // transfer state
  logic [3:0]        bitCnt;                // bits of the current byte
  logic              ackOn;                 // in the ack slot we drive
  logic [7:0]        rxShift;               // incoming byte
  logic [7:0]        txByte;                // outgoing byte
  logic [7:0]        ptr;                   // internal address pointer
  logic              wrote;                 // data byte taken this frame
  logic              hostAck;               // host acked the last byte
  logic [BUSY_W-1:0] busyCnt;               // write-cycle timer
  logic              memWe;                 // array write strobe
  logic [7:0]        memAddr;               // array write location
  logic [7:0]        memData;               // array write data
  logic [7:0]        mem [ARRAY_BYTES];     // storage array
  logic              ctrlMatch;             // control byte addresses us

  // ------------------------------------------------------------
  // pin synchronisers and condition detect
  // ------------------------------------------------------------

  // two flops on each pin, then one of history
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclMeta <= 1'b1;
      sclS    <= 1'b1;
      sclP    <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS    <= 1'b1;
      sdaP    <= 1'b1;
    end else begin
      sclMeta <= scl;
      sclS    <= sclMeta;
      sclP    <= sclS;
      sdaMeta <= sdaIn;
      sdaS    <= sdaMeta;
      sdaP    <= sdaS;
    end
  end

  assign sclRise   = sclS & ~sclP;
  assign sclFall   = ~sclS & sclP;
  // sda moving while scl stays high
  assign startSeen = sclS & sclP & sdaP & ~sdaS;
  assign stopSeen  = sclS & sclP & ~sdaP & sdaS;
  assign ctrlMatch = (rxShift[7:4] == CTRL_CODE);

  // ------------------------------------------------------------
  // write-cycle timer
  // ------------------------------------------------------------

  // runs after a stop that closed a write with data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busyCnt   <= '0;
      writeBusy <= 1'b0;
    end else if (stopSeen && wrote) begin
      busyCnt   <= BUSY_W'(WRITE_CYC - 1);
      writeBusy <= 1'b1;
    end else if (busyCnt != '0) begin
      busyCnt <= busyCnt - 1'b1;
    end else begin
      writeBusy <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // storage array
  // ------------------------------------------------------------

  // one flop row per location, reset to the factory image
  // identifier preloaded in upper half
  generate
    for (genvar i = 0; i < ARRAY_BYTES; i++) begin : g_row
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          mem[i] <= memInit(i);
        end else if (memWe && memAddr == 8'(i)) begin
          mem[i] <= memData;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------

  // start, stop, bit counting, ack slots and pointer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= sIdle;
      bitCnt  <= 4'h0;
      ackOn   <= 1'b0;
      rxShift <= 8'h00;
      txByte  <= 8'h00;
      ptr     <= 8'h00;
      wrote   <= 1'b0;
      hostAck <= 1'b0;
      sdaOe   <= 1'b0;
      sdaOut  <= 1'b0;
      memWe   <= 1'b0;
      memAddr <= 8'h00;
      memData <= 8'h00;
    end else begin
      memWe  <= 1'b0;
      sdaOut <= 1'b0;
      if (startSeen) begin
        // repeated start keeps bytes already stored and the wrote flag, pointer kept
        state  <= sCtrl;
        bitCnt <= 4'h0;
        ackOn  <= 1'b0;
        sdaOe  <= 1'b0;
      end else if (stopSeen) begin
        // frame over, line released
        state  <= sIdle;
        ackOn  <= 1'b0;
        sdaOe  <= 1'b0;
        wrote  <= 1'b0;
      end else begin
        unique case (state)
          sIdle: begin
            sdaOe <= 1'b0;
          end
          sCtrl, sAddr, sWdata: begin
            if (sclRise && bitCnt < BITS_PER_BYTE) begin
              // shift in on the rising edge
              rxShift <= {rxShift[6:0], sdaS};
              bitCnt  <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == BITS_PER_BYTE && !ackOn) begin
              // ack slot opens
              if (state == sCtrl) begin
                if (ctrlMatch && !writeBusy) begin
                  ackOn <= 1'b1;
                  sdaOe <= 1'b1;
                  state <= rxShift[0] ? sRdata : sAddr;
                end else begin
                  state <= sIdle;
                end
              end else if (state == sAddr) begin
                // word address goes to the pointer
                ackOn <= 1'b1;
                sdaOe <= 1'b1;
                ptr   <= rxShift;
                state <= sWdata;
              end else begin
                // data byte: store below the protected half
                ackOn <= 1'b1;
                sdaOe <= 1'b1;
                wrote <= 1'b1;
                memWe   <= (ptr < PROT_BASE);
                memAddr <= ptr;
                memData <= rxShift;
                ptr <= ptr + 8'h01;
              end
            end else if (sclFall && ackOn) begin
              // ack slot closes
              ackOn  <= 1'b0;
              sdaOe  <= 1'b0;
              bitCnt <= 4'h0;
            end
          end
          sRdata: begin
            if (sclFall && ackOn) begin
              // first byte after ack of the read control
              // byte at the pointer, then pointer plus one
              ackOn  <= 1'b0;
              txByte <= mem[ptr];
              sdaOe  <= ~mem[ptr][7];
              ptr    <= ptr + 8'h01;
              bitCnt <= 4'h0;
            end else if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt < BITS_PER_BYTE) begin
              // next bit, msb first; low bit pulls the line
              sdaOe <= ~txByte[3'(4'h7 - bitCnt)];
            end else if (sclFall) begin
              // release for the host ack
              sdaOe <= 1'b0;
              state <= sMack;
            end
          end
          sMack: begin
            if (sclRise) begin
              hostAck <= ~sdaS;
            end else if (sclFall && hostAck) begin
              // host ack: stream the next byte
              txByte  <= mem[ptr];
              sdaOe   <= ~mem[ptr][7];
              ptr     <= ptr + 8'h01;
              bitCnt  <= 4'h0;
              hostAck <= 1'b0;
              state   <= sRdata;
            end else if (sclFall) begin
              // nack: back to idle, off the line until the next start
              sdaOe <= 1'b0;
              state <= sIdle;
            end
          end
          default: begin
            state <= sIdle;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> design/eeprom_pkg.sv
// constants shared by the two-wire serial eeprom client
// assumes a 100 MHz system clock and a host that drives the serial clock
`default_nettype none
package eeprom_pkg;

  // ------------------------------------------------------------
  // bus framing
  // ------------------------------------------------------------
  localparam logic [3:0]  CTRL_CODE     = 4'ha;      // device-type pattern 1010
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;      // data bits before the ack slot

  // ------------------------------------------------------------
  // array layout
  // ------------------------------------------------------------
  localparam int          ARRAY_BYTES   = 256;       // 2 kbit array
  localparam logic [7:0]  PROT_BASE     = 8'h80;     // start of write-protected half
  localparam logic [7:0]  ID48_BASE     = 8'hfa;     // first byte of 48-bit identifier
  localparam logic [7:0]  ID64_BASE     = 8'hf8;     // first byte of 64-bit identifier
  localparam logic [7:0]  ARRAY_LAST    = 8'hff;     // last array location
  localparam logic [7:0]  FILL_LOW      = 8'h00;     // reset value of the user half
  localparam logic [7:0]  FILL_HIGH     = 8'hff;     // unused protected locations
  localparam logic [15:0] ENCAP_WORD    = 16'hfffe;  // marks an encapsulated 48-bit id
  localparam logic [15:0] RESV_WORD     = 16'hffff;  // also reserved for encapsulation

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;        // 100 MHz system clock
  localparam int          WRITE_TIME_NS = 5000000;   // internal write cycle length
  localparam int          WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int          BUSY_W        = 20;        // width of write-cycle counter

  // ------------------------------------------------------------
  // transfer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    sIdle,     // waiting for a start
    sCtrl,     // receiving control byte
    sAddr,     // receiving word address
    sWdata,    // receiving write data
    sRdata,    // shifting out read data
    sMack      // sampling the host ack
  } xfer_state_t;

endpackage

`default_nettype wire

// >>> verif/eeprom_client_props.sv
// pin-level assertions for the eeprom client
// assumes one clock domain and a host with 8 clk per scl period
`timescale 1ns/10ps
`default_nettype none
module eeprom_client_props #(
  parameter int WRITE_CYC = 100
)(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins and status
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic writeBusy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  int busyCnt;  // busy samples in a row

  // ------------------------------------------------------------
  // helper: length of the current busy run
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busyCnt <= 0;
    else busyCnt <= writeBusy ? busyCnt + 1 : 0;
  end

  // an ack or data bit is held for five clk once driven
  sequence s_held;
    sdaOe [*5];
  endsequence

  property p_drain; sdaOut == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("sda driven high");
  property p_hold; $rose(sdaOe) |-> s_held; endproperty
  a_hold: assert property (p_hold) else $error("bit not held");
  property p_stable; scl && $past(scl) && $past(scl, 2) |-> $stable(sdaOe); endproperty
  a_stable: assert property (p_stable) else $error("sda moved in scl high");
  property p_quiet; writeBusy |-> !sdaOe; endproperty
  a_quiet: assert property (p_quiet) else $error("ack while busy");
  property p_bstart; $rose(writeBusy) |-> scl && sdaIn; endproperty
  a_bstart: assert property (p_bstart) else $error("busy not after stop");
  property p_blen; $fell(writeBusy) |-> busyCnt >= WRITE_CYC - 1 && busyCnt <= WRITE_CYC + 1; endproperty
  a_blen: assert property (p_blen) else $error("busy length wrong");
  property p_bmax; busyCnt <= WRITE_CYC + 1; endproperty
  a_bmax: assert property (p_bmax) else $error("busy too long");
  property p_rst; $rose(resetn) |-> !sdaOe && !writeBusy; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
endmodule

bind eeprom_client eeprom_client_props #(.WRITE_CYC(WRITE_CYC)) props (
  .clk(clk), .resetn(resetn), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .writeBusy(writeBusy));
`default_nettype wire

// >>> verif/eeprom_host.sv
// two-wire bus host model, 8 clk per scl period
// assumes the bench resolves sda with a pull-up
`timescale 1ns/10ps
`default_nettype none
module eeprom_host (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda,
  output var  logic scl,
  output var  logic sdaPull
);
  // idle bus: scl high, sda released
  initial begin
    scl     = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // start or repeated start, ends with scl low
  task automatic start();
    sdaPull <= 1'b0;
    // give the client time to let go of sda before scl rises
    wt(4);
    scl <= 1'b1;
    wt(4);
    sdaPull <= 1'b1;
    wt(4);
    scl <= 1'b0;
    wt(2);
  endtask
  // stop, scl then stands high
  task automatic stop();
    sdaPull <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sdaPull <= 1'b0;
    wt(4);
  endtask
  // one bit: data set in scl low, sampled mid high
  task automatic bit1(input logic b, output logic r);
    sdaPull <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
    wt(1);
  endtask
  // host ack bit 0 asks for the next byte
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
      q[i] = r;
    end
    bit1(ab, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// >>> verif/i2c_eeprom_read_and_node_id_tb_top.sv
// self-checking bench for eeprom client reads, polling and identifier
// assumes the host model drives scl and a pull-up on sda
`timescale 1ns/10ps
`default_nettype none
module i2c_eeprom_read_and_node_id_tb_top;
  import eeprom_pkg::*;
  localparam int          WCYC = 150;             // short write cycle
  localparam logic [23:0] PFX  = 24'h3c6e19;      // arbitrary value
  localparam logic [39:0] EXT  = 40'h00004d2b71;  // arbitrary value
  localparam logic [39:0] EXT64 = 40'hfffe4d2b71; // arbitrary value, reserved lead word
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sdaPull;
  logic       sdaOe;
  logic       writeBusy;
  wire logic  sda;
  logic       scl2;        // second bus: 64-bit variant
  logic       sdaPull2;
  logic       sdaOe2;
  logic       writeBusy2;
  wire logic  sda2;
  logic [7:0] got [256];   // bytes read back
  logic [47:0] id48;       // 48-bit id as read
  int         nMismatch;
  int         totalChecks;
  int         seed = 95526;
  logic [7:0] img [256];  // expected array
  logic [7:0] q;
  logic [7:0] a;
  logic       ak;
  // open-drain wire with pull-up
  assign sda = ~(sdaOe | sdaPull);
  assign sda2 = ~(sdaOe2 | sdaPull2);
  eeprom_client #(.WRITE_CYC(WCYC), .ID_PREFIX(PFX), .ID_EXT(EXT)) dut (.clk(clk), .resetn(resetn),
    .scl(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .writeBusy(writeBusy));
  eeprom_host h (.clk(clk), .sda(sda), .scl(scl), .sdaPull(sdaPull));
  eeprom_client #(.WRITE_CYC(WCYC), .ID_IS_64(1'b1), .ID_PREFIX(PFX), .ID_EXT(EXT64)) dut64 (.clk(clk),
    .resetn(resetn), .scl(scl2), .sdaIn(sda2), .sdaOut(), .sdaOe(sdaOe2), .writeBusy(writeBusy2));
  eeprom_host h2 (.clk(clk), .sda(sda2), .scl(scl2), .sdaPull(sdaPull2));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // prefix taken from a parameter, not fixed
  function automatic logic [7:0] factory(input logic [7:0] x);
    logic [47:0] id;
    id = {PFX, EXT[23:0]};
    if (x < PROT_BASE) return FILL_LOW;
    if (x < ID48_BASE) return FILL_HIGH;
    return id[8 * (8'hff - x) +: 8];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected at %0t: byte %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected at %0t: flag %b want %b", $time, g, e);
    end
  endtask
  task automatic chk_id(input logic [63:0] g, input logic [63:0] e);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected at %0t: id %h want %h", $time, g, e);
    end
  endtask
  // host inserts the reserved word between prefix and extension
  function automatic logic [63:0] encap48(input logic [47:0] v);
    return {v[47:24], ENCAP_WORD, v[23:0]};
  endfunction
  task automatic ctrl(input logic rd, output logic ack);
    h.start();
    h.xfer({CTRL_CODE, 3'h0, rd}, 1'b1, q, ack);
  endtask
  task automatic rd_seq(input logic [7:0] s, input int n);
    ctrl(1'b0, ak);
    h.xfer(s, 1'b1, q, ak);
    ctrl(1'b1, ak);
    chk_flag(ak, 1'b1);
    for (int i = 0; i < n; i++) begin
      h.xfer(8'hff, i == n - 1, q, ak);
      got[8'(s + i)] = q;
      chk(q, img[8'(s + i)]);
    end
    h.stop();
    h.wt(10);
    chk_flag(writeBusy, 1'b0);
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    int n;
    ctrl(1'b0, ak);
    h.xfer(s, 1'b1, q, ak);
    h.xfer(d, 1'b1, q, ak);
    h.stop();
    if (s < PROT_BASE) img[s] = d;
    ctrl(1'b0, ak);
    chk_flag(ak, 1'b0);
    n = 0;
    while (!ak && n < 20) begin
      h.stop();
      ctrl(1'b0, ak);
      n++;
    end
    chk_flag(ak, 1'b1);
    h.stop();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    nMismatch++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    nMismatch = 0;
    totalChecks = 0;
    for (int i = 0; i < 256; i++) img[i] = factory(8'(i));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (5) @(posedge clk);
    rd_seq(8'hf8, 10);
    id48 = {got[8'hfa], got[8'hfb], got[8'hfc], got[8'hfd], got[8'hfe], got[8'hff]};
    chk_id(encap48(id48), {PFX, 16'hfffe, EXT[23:0]});
    $display("test factory done");
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'h7f : 8'($random(seed)) & 8'h7f;
      wr(a, 8'($random(seed)));
      ctrl(1'b1, ak);
      h.xfer(8'hff, 1'b1, q, ak);
      h.stop();
      chk(q, img[8'(a + 1)]);
      rd_seq(a, 2);
    end
    $display("test write done");
    wr(8'hfa, ~img[8'hfa]);
    rd_seq(8'hfa, 6);
    $display("test protect done");
    for (int k = 0; k < 4; k++) begin
      h.start();
      h.xfer({CTRL_CODE ^ 4'(1 << k), 4'h0}, 1'b1, q, ak);
      chk_flag(ak, 1'b0);
      h.stop();
    end
    $display("test badcode done");
    // second device holds the 64-bit identifier
    h2.start();
    h2.xfer({CTRL_CODE, 4'h0}, 1'b1, q, ak);
    h2.xfer(ID64_BASE, 1'b1, q, ak);
    h2.start();
    h2.xfer({CTRL_CODE, 4'h1}, 1'b1, q, ak);
    chk_flag(ak, 1'b1);
    for (int i = 0; i < 8; i++) begin
      h2.xfer(8'hff, i == 7, q, ak);
      got[ID64_BASE + 8'(i)] = q;
    end
    h2.stop();
    h2.wt(10);
    for (int i = 0; i < 3; i++) begin
      chk(got[ID64_BASE + 8'(i)], PFX[8 * (2 - i) +: 8]);
      chk(got[8'hfd + 8'(i)], EXT64[8 * (2 - i) +: 8]);
    end
    chk_flag({got[8'hfb], got[8'hfc]} != ENCAP_WORD && {got[8'hfb], got[8'hfc]} != RESV_WORD, 1'b1);
    chk_flag(writeBusy2, 1'b0);
    $display("test id64 done");
    report_and_stop();
  end
endmodule
`default_nettype wire
